/* File: design/sfmcd_sync.v */
// two-stage synchroniser, one stage pair per bit
module sfmcd_sync #(
   parameter WIDTH = 1
) (
   input  wire             clk,
   input  wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] meta_q;  // first stage, read only by second
   reg [WIDTH-1:0] sync_q;  // second stage

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
         // per-bit double flop
         always @(posedge clk) begin
            meta_q[gi] <= din[gi];
            sync_q[gi] <= meta_q[gi];
         end
      end
   endgenerate

   assign dout = sync_q;

endmodule

/* File: design/sfmcd_top.v */
// Functional notes
// - whole-array erase needs write latch set
// - chip select must rise right after opcode
// - erase sets busy, clears write latch
// - whole-array erase ignored if protected
// - C0 parameter sets dummy clock count, four-line mode only
// - parameter low bits set wrap length
// - wrap length kept across mode switch
// - B7 sets wide address flag
// - E9 clears wide address flag
// - wide mode only lengthens 4B and 44 address fields, 90 stays at 24 bits
// - 90 outputs maker then device code
// - 9F outputs maker, type, capacity
// - id command ignored during busy cycle
// - chip select rise ends id output
// - 4B outputs 128-bit unique number
// - security erase needs write latch set
// - chip select rise after last address bit
// - security erase runs sector erase time
// - locked security register ignores erase
// - security register chosen by address bits
// - whole-array erase has no address bytes
// - suspend only when busy, not suspended
`include "sfmcd_map.vh"

module sfmcd_top #(
   parameter [7:0]   MAKER_CODE        = 8'hA5,  // arbitrary value
   parameter [7:0]   DEVICE_CODE       = 8'h5A,  // arbitrary value
   parameter [7:0]   MEMORY_TYPE       = 8'h3C,  // arbitrary value
   parameter [7:0]   CAPACITY_CODE     = 8'hC3,  // arbitrary value
   parameter [127:0] UNIQUE_ID         = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
   parameter         CHIP_ERASE_US     = `SFMCD_CHIP_ERASE_US,
   parameter         SECTOR_ERASE_US   = `SFMCD_SECTOR_ERASE_US,
   parameter         CLK_MHZ           = `SFMCD_CLK_MHZ
) (
   input  wire       CLK,
   input  wire       RESET_N,
   input  wire       CS_N,
   input  wire       SCLK,
   input  wire [3:0] IO_IN,
   output wire [3:0] IO_OUT,
   output wire [3:0] IO_OE_N,
   input  wire       FOUR_LINE_MODE,
   input  wire [4:0] BLOCK_PROTECT_FIELD,
   input  wire       SEC_REG_TWO_LOCK,
   input  wire       SEC_REG_THREE_LOCK,
   input  wire [1:0] SUSPEND_FLAGS,
   output wire       WRITE_LATCH_FLAG,
   output wire       IN_PROGRESS_FLAG,
   output wire       ADDRESS_WIDTH_FLAG,
   output wire [3:0] DUMMY_CLOCKS,
   output wire [6:0] WRAP_BYTES,
   output wire       CHIP_ERASE_START,
   output wire       SEC_ERASE_START,
   output wire       SEC_ERASE_SELECT,
   output wire       SUSPEND_REQUEST
);

   // self-timed durations in clock cycles
   localparam [31:0] CHIP_ERASE_CYCLES  = CHIP_ERASE_US * CLK_MHZ;
   localparam [31:0] SECTOR_ERASE_CYCLES = SECTOR_ERASE_US * CLK_MHZ;

   // decoder states
   localparam [2:0] ST_CMD    = 3'h0;  // collecting opcode
   localparam [2:0] ST_ADDR   = 3'h1;  // collecting address/param
   localparam [2:0] ST_WAIT   = 3'h2;  // waiting for chip select rise
   localparam [2:0] ST_OUT    = 3'h3;  // shifting id data out
   localparam [2:0] ST_IGNORE = 3'h4;  // discard until deselect

   wire [3:0] io_s;    // synchronised data lines
   wire       sclk_s;  // synchronised serial clock
   wire       cs_n_s;  // synchronised chip select

   reg         sclk_prev_q;     // serial clock edge detector
   reg         cs_n_prev_q;     // chip select edge detector
   reg [2:0]   st_q;            // decoder state
   reg [7:0]   cmd_q;           // opcode shift register
   reg [31:0]  addr_q;          // address/parameter shift register
   reg [5:0]   cnt_q;           // bits in current phase
   reg [5:0]   need_q;          // bits needed in address phase
   reg         exact_q;         // phase just ended on a byte boundary
   reg [127:0] out_sr_q;        // id output shift register
   reg [3:0]   io_out_q;        // driven data
   reg [3:0]   oe_n_q;          // drive enables, active low
   reg         wel_q;           // write latch flag
   reg         busy_q;          // in-progress flag
   reg [31:0]  busy_cnt_q;      // remaining self-timed cycles
   reg         wide_q;          // address width flag
   reg [1:0]   dummy_code_q;    // dummy clock code
   reg [3:0]   dummy_q;         // dummy clock count
   reg [6:0]   wrap_q;          // wrap length in bytes
   reg         ce_start_q;      // chip erase start pulse
   reg         se_start_q;      // security erase start pulse
   reg         se_sel_q;        // security register selected
   reg         susp_q;          // suspend request pulse

   reg [5:0]   step;            // bits per serial clock edge
   reg [5:0]   cnt_nx;          // bit count after this edge
   reg [7:0]   cmd_nx;          // opcode after this edge
   reg [31:0]  addr_nx;         // address after this edge
   reg [5:0]   alen;            // address length in bits
   reg         sr_two;          // address hits security register two
   reg         sr_three;        // address hits security register three
   reg [1:0]   pcode_d;         // dummy code from parameter byte

   // synchronise pins into the clock domain
   sfmcd_sync #(
      .WIDTH (6)
   ) u_sync (
      .clk  (CLK),
      .din  ({CS_N, SCLK, IO_IN}),
      .dout ({cs_n_s, sclk_s, io_s})
   );

   wire sclk_rise = sclk_s & ~sclk_prev_q;
   wire sclk_fall = ~sclk_s & sclk_prev_q;
   wire cs_rise   = cs_n_s & ~cs_n_prev_q;

   // shift and length helpers
   always @* begin
      step    = FOUR_LINE_MODE ? `SFMCD_STEP_QUAD : `SFMCD_STEP_SINGLE;
      cnt_nx  = cnt_q + step;
      cmd_nx  = FOUR_LINE_MODE ? {cmd_q[3:0], io_s}
                               : {cmd_q[6:0], io_s[0]};
      addr_nx = FOUR_LINE_MODE ? {addr_q[27:0], io_s}
                               : {addr_q[30:0], io_s[0]};
      alen    = wide_q ? `SFMCD_ADDR_WIDE_BITS : `SFMCD_ADDR_NARROW_BITS;
      sr_two   = (addr_q[`SFMCD_SR_TOP_MSB:`SFMCD_SR_TOP_LSB]
                  == `SFMCD_SR_TOP_VAL)
               && (addr_q[`SFMCD_SR_GAP_MSB:`SFMCD_SR_GAP_LSB]
                  == `SFMCD_SR_GAP_VAL)
               && (addr_q[`SFMCD_SR_SEL_MSB:`SFMCD_SR_SEL_LSB]
                  == `SFMCD_SR_SEL_TWO);
      sr_three = (addr_q[`SFMCD_SR_TOP_MSB:`SFMCD_SR_TOP_LSB]
                  == `SFMCD_SR_TOP_VAL)
               && (addr_q[`SFMCD_SR_GAP_MSB:`SFMCD_SR_GAP_LSB]
                  == `SFMCD_SR_GAP_VAL)
               && (addr_q[`SFMCD_SR_SEL_MSB:`SFMCD_SR_SEL_LSB]
                  == `SFMCD_SR_SEL_THREE);
      pcode_d  = addr_q[`SFMCD_DUMMY_MSB:`SFMCD_DUMMY_LSB];
   end

   // command decoder, flags and output shifter
   always @(posedge CLK) begin
      if (!RESET_N) begin
         sclk_prev_q  <= 1'b0;
         cs_n_prev_q  <= 1'b1;
         st_q         <= ST_CMD;
         cmd_q        <= 8'h00;
         addr_q       <= 32'h0000_0000;
         cnt_q        <= 6'h00;
         need_q       <= 6'h00;
         exact_q      <= 1'b0;
         out_sr_q     <= 128'h0;
         io_out_q     <= 4'h0;
         oe_n_q       <= `SFMCD_OE_NONE;
         wel_q        <= 1'b0;
         busy_q       <= 1'b0;
         busy_cnt_q   <= 32'h0000_0000;
         wide_q       <= 1'b0;
         dummy_code_q <= `SFMCD_DUMMY_CODE_4;
         dummy_q      <= `SFMCD_DUMMY_4;
         wrap_q       <= `SFMCD_WRAP_8;
         ce_start_q   <= 1'b0;
         se_start_q   <= 1'b0;
         se_sel_q     <= 1'b0;
         susp_q       <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
         cs_n_prev_q <= cs_n_s;
         ce_start_q  <= 1'b0;
         se_start_q  <= 1'b0;
         susp_q      <= 1'b0;
         if (busy_q) begin
            busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
            if (busy_cnt_q == 32'h0000_0001)
               busy_q <= 1'b0;
         end
         if (cs_n_s) begin
            // deselected: reset decoder, stop output
            st_q    <= ST_CMD;
            cnt_q   <= 6'h00;
            exact_q <= 1'b0;
            oe_n_q  <= `SFMCD_OE_NONE;
            if (cs_rise && exact_q && st_q == ST_WAIT) begin
               case (cmd_q)
                  `SFMCD_OP_WRITE_ENABLE: begin
                     if (!busy_q)
                        wel_q <= 1'b1;
                  end
                  `SFMCD_OP_ERASE_CHIP_A,
                  `SFMCD_OP_ERASE_CHIP_B: begin
                     if (wel_q && !busy_q && BLOCK_PROTECT_FIELD == 5'h00)
                     begin
                        busy_q     <= 1'b1;
                        busy_cnt_q <= CHIP_ERASE_CYCLES;
                        wel_q      <= 1'b0;
                        ce_start_q <= 1'b1;
                     end
                  end
                  `SFMCD_OP_ERASE_SEC_REG: begin
                     if (wel_q && !busy_q
                         && ((sr_two && !SEC_REG_TWO_LOCK)
                         || (sr_three && !SEC_REG_THREE_LOCK))) begin
                        busy_q     <= 1'b1;
                        busy_cnt_q <= SECTOR_ERASE_CYCLES;
                        wel_q      <= 1'b0;
                        se_start_q <= 1'b1;
                        se_sel_q   <= sr_three;
                     end
                  end
                  `SFMCD_OP_ENTER_WIDE: wide_q <= 1'b1;
                  `SFMCD_OP_EXIT_WIDE: wide_q <= 1'b0;
                  `SFMCD_OP_SET_READ_PARAM: begin
                     // reserved dummy code keeps old count
                     if (pcode_d != `SFMCD_DUMMY_RESERVED) begin
                        dummy_code_q <= pcode_d;
                        dummy_q <= (pcode_d == `SFMCD_DUMMY_CODE_4)
                                   ? `SFMCD_DUMMY_4
                                   : (pcode_d == `SFMCD_DUMMY_CODE_6)
                                   ? `SFMCD_DUMMY_6 : `SFMCD_DUMMY_8;
                     end
                     case (addr_q[`SFMCD_WRAP_MSB:`SFMCD_WRAP_LSB])
                        `SFMCD_WRAP_CODE_8:  wrap_q <= `SFMCD_WRAP_8;
                        `SFMCD_WRAP_CODE_16: wrap_q <= `SFMCD_WRAP_16;
                        `SFMCD_WRAP_CODE_32: wrap_q <= `SFMCD_WRAP_32;
                        default:             wrap_q <= `SFMCD_WRAP_64;
                     endcase
                  end
                  `SFMCD_OP_SUSPEND: begin
                     if (busy_q && SUSPEND_FLAGS == 2'h0)
                        susp_q <= 1'b1;
                  end
                  default: ;
               endcase
            end
         end else if (sclk_rise) begin
            case (st_q)
               ST_CMD: begin
                  cmd_q <= cmd_nx;
                  cnt_q <= cnt_nx;
                  if (cnt_nx == `SFMCD_OPCODE_BITS) begin
                     cnt_q <= 6'h00;
                     if (busy_q && cmd_nx != `SFMCD_OP_SUSPEND)
                        st_q <= ST_IGNORE;
                     else begin
                        case (cmd_nx)
                           `SFMCD_OP_WRITE_ENABLE,
                           `SFMCD_OP_ERASE_CHIP_A,
                           `SFMCD_OP_ERASE_CHIP_B,
                           `SFMCD_OP_ENTER_WIDE,
                           `SFMCD_OP_EXIT_WIDE,
                           `SFMCD_OP_SUSPEND: begin
                              st_q    <= ST_WAIT;
                              exact_q <= 1'b1;
                           end
                           `SFMCD_OP_SET_READ_PARAM: begin
                              st_q   <= FOUR_LINE_MODE ? ST_ADDR
                                                       : ST_IGNORE;
                              need_q <= `SFMCD_PARAM_BITS;
                           end
                           `SFMCD_OP_MAKER_DEVICE: begin
                              st_q   <= ST_ADDR;
                              need_q <= `SFMCD_ADDR_NARROW_BITS;
                           end
                           `SFMCD_OP_UNIQUE_ID: begin
                              st_q   <= ST_ADDR;
                              need_q <= alen + `SFMCD_DUMMY_BYTE_BITS;
                           end
                           `SFMCD_OP_ERASE_SEC_REG: begin
                              st_q   <= ST_ADDR;
                              need_q <= alen;
                           end
                           `SFMCD_OP_THREE_BYTE_ID: begin
                              st_q     <= ST_OUT;
                              out_sr_q <= {MAKER_CODE, MEMORY_TYPE,
                                           CAPACITY_CODE, 104'h0};
                           end
                           default: st_q <= ST_IGNORE;
                        endcase
                     end
                  end
               end
               ST_ADDR: begin
                  addr_q <= addr_nx;
                  cnt_q  <= cnt_nx;
                  if (cnt_nx == need_q) begin
                     case (cmd_q)
                        `SFMCD_OP_MAKER_DEVICE: begin
                           st_q     <= ST_OUT;
                           out_sr_q <= {8{MAKER_CODE, DEVICE_CODE}};
                        end
                        `SFMCD_OP_UNIQUE_ID: begin
                           st_q     <= ST_OUT;
                           out_sr_q <= UNIQUE_ID;
                        end
                        default: begin
                           st_q    <= ST_WAIT;
                           exact_q <= 1'b1;
                        end
                     endcase
                  end
               end
               ST_WAIT: begin
                  exact_q <= 1'b0;
                  st_q    <= ST_IGNORE;
               end
               ST_OUT: ;
               ST_IGNORE: ;
               default: st_q <= ST_IGNORE;
            endcase
         end else if (sclk_fall && st_q == ST_OUT) begin
            if (FOUR_LINE_MODE) begin
               io_out_q <= out_sr_q[127:124];
               out_sr_q <= {out_sr_q[123:0], 4'h0};
               oe_n_q   <= `SFMCD_OE_QUAD;
            end else begin
               io_out_q <= {2'b00, out_sr_q[127], 1'b0};
               out_sr_q <= {out_sr_q[126:0], 1'b0};
               oe_n_q   <= `SFMCD_OE_SINGLE;
            end
         end
      end
   end

   assign IO_OUT             = io_out_q;
   assign IO_OE_N            = oe_n_q;
   assign WRITE_LATCH_FLAG   = wel_q;
   assign IN_PROGRESS_FLAG   = busy_q;
   assign ADDRESS_WIDTH_FLAG = wide_q;
   assign DUMMY_CLOCKS       = dummy_q;
   assign WRAP_BYTES         = wrap_q;
   assign CHIP_ERASE_START   = ce_start_q;
   assign SEC_ERASE_START    = se_start_q;
   assign SEC_ERASE_SELECT   = se_sel_q;
   assign SUSPEND_REQUEST    = susp_q;

endmodule

/* File: dv/sfmcd_host.sv */
// host controller model: drives select, clock and data
module sfmcd_host (
   input  wire       clk,
   input  wire [3:0] io_out,
   output logic      cs_n,
   output logic      sclk,
   output logic [3:0] io_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus: deselected, clock still
   initial {cs_n, sclk, io_in} = 6'h20;

   // wait whole system clocks
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask

   // one select: n bits out msb first, rn bits back
   // any bit count in single-line mode, multiples of four in quad; address bits come from v
   task automatic cmd(input logic [63:0] v, input int n, input logic q,
                      input int rn, output logic [63:0] rd);
      int i;
      rd = '0;
      cs_n <= 1'b0;
      tick(4);
      for (i = n - 1; i >= 0; i = i - (q ? 4 : 1)) begin
         io_in <= q ? v[i -: 4] : {~io_in[3:1], v[i]};
         tick(4);
         sclk <= 1'b1;
         tick(4);
         sclk <= 1'b0;
      end
      // released lines show a changing pattern
      io_in <= ~io_in;
      for (i = 0; i < rn; i++) begin
         tick(4);
         sclk <= 1'b1;
         tick(2);
         rd = {rd[62:0], io_out[1]};
         tick(2);
         sclk <= 1'b0;
      end
      tick(4);
      // deselect right after the last bit
      cs_n <= 1'b1;
      tick(6);
   endtask
endmodule

/* File: dv/sfmcd_top_chk.sv */
// checker on the decoder's ports
module sfmcd_top_chk #(
   parameter CHIP_ERASE_US   = 1000,
   parameter SECTOR_ERASE_US = 100,
   parameter CLK_MHZ         = 40
) (
   input wire       CLK,
   input wire       RESET_N,
   input wire       CS_N,
   input wire       FOUR_LINE_MODE,
   input wire [4:0] BLOCK_PROTECT_FIELD,
   input wire       SEC_REG_TWO_LOCK,
   input wire       SEC_REG_THREE_LOCK,
   input wire [1:0] SUSPEND_FLAGS,
   input wire       WRITE_LATCH_FLAG,
   input wire       IN_PROGRESS_FLAG,
   input wire       ADDRESS_WIDTH_FLAG,
   input wire [3:0] DUMMY_CLOCKS,
   input wire [6:0] WRAP_BYTES,
   input wire       CHIP_ERASE_START,
   input wire       SEC_ERASE_START,
   input wire       SEC_ERASE_SELECT,
   input wire       SUSPEND_REQUEST,
   input wire [3:0] IO_OE_N
);
   localparam int CE_N = CHIP_ERASE_US * CLK_MHZ;
   localparam int SE_N = SECTOR_ERASE_US * CLK_MHZ;
   logic [31:0] busy_q;  // busy clocks
   logic        chip_q;  // whole-array cycle
   logic        sus_q;   // suspend seen
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   // count busy clocks and note the kind of cycle
   always @(posedge CLK) begin
      busy_q <= (RESET_N && IN_PROGRESS_FLAG) ? busy_q + 32'h0000_0001 : '0;
      if (CHIP_ERASE_START || SEC_ERASE_START)
         chip_q <= CHIP_ERASE_START;
      if (CHIP_ERASE_START || SEC_ERASE_START || !RESET_N)
         sus_q <= 1'b0;
      else if (SUSPEND_REQUEST)
         sus_q <= 1'b1;
   end

   sequence s_start;
      CHIP_ERASE_START || SEC_ERASE_START;
   endsequence
   sequence s_busy_wel;
      ##[0:1] IN_PROGRESS_FLAG ##[0:2] !WRITE_LATCH_FLAG;
   endsequence
   sequence s_desel;
      CS_N [*6];
   endsequence

   property p_ce_wel;
      CHIP_ERASE_START |-> $past(WRITE_LATCH_FLAG);
   endproperty
   property p_ce_prot;
      CHIP_ERASE_START |-> BLOCK_PROTECT_FIELD == 5'h00;
   endproperty
   property p_start_busy;
      s_start |-> s_busy_wel;
   endproperty
   property p_time;
      $fell(IN_PROGRESS_FLAG) && !sus_q |->
         busy_q + 2 >= (chip_q ? CE_N : SE_N) &&
         busy_q <= (chip_q ? CE_N : SE_N) + 2;
   endproperty
   property p_se_wel;
      SEC_ERASE_START |-> $past(WRITE_LATCH_FLAG);
   endproperty
   property p_se_lock;
      SEC_ERASE_START |->
         !(SEC_ERASE_SELECT ? SEC_REG_THREE_LOCK : SEC_REG_TWO_LOCK);
   endproperty
   property p_busy_quiet;
      IN_PROGRESS_FLAG |=> $stable(ADDRESS_WIDTH_FLAG);
   endproperty
   property p_susp;
      SUSPEND_REQUEST |-> $past(IN_PROGRESS_FLAG) && SUSPEND_FLAGS == 2'h0;
   endproperty
   property p_param;
      $changed(DUMMY_CLOCKS) || $changed(WRAP_BYTES) |-> FOUR_LINE_MODE;
   endproperty
   property p_idle_oe;
      s_desel |-> IO_OE_N == 4'hF;
   endproperty
   property p_wel_fall;
      $fell(WRITE_LATCH_FLAG) |-> ##[0:1] IN_PROGRESS_FLAG;
   endproperty

   a_ce_wel: assert property (p_ce_wel)
      else $error("erase, no latch");
   a_ce_prot: assert property (p_ce_prot)
      else $error("erase while protected");
   a_start_busy: assert property (p_start_busy)
      else $error("bad flags after start");
   a_time: assert property (p_time)
      else $error("bad cycle length");
   a_se_wel: assert property (p_se_wel)
      else $error("sec erase, no latch");
   a_se_lock: assert property (p_se_lock)
      else $error("locked reg erased");
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("decoded while busy");
   a_susp: assert property (p_susp)
      else $error("bad suspend");
   a_param: assert property (p_param)
      else $error("params set outside quad");
   a_idle_oe: assert property (p_idle_oe)
      else $error("driven while deselected");
   a_wel_fall: assert property (p_wel_fall)
      else $error("latch cleared, no cycle");
endmodule

/* File: dv/tb_top.sv */
`include "sfmcd_map.vh"
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin \
   error_cnt++; $display("ERROR %s exp %0h got %0h", nm, e, a); end end

// bench for the command decoder
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [7:0]   MK  = 8'h3A;  // arbitrary value
   localparam [7:0]   DV  = 8'h61;  // arbitrary value
   localparam [7:0]   TY  = 8'h27;  // arbitrary value
   localparam [7:0]   CP  = 8'h18;  // arbitrary value
   localparam [127:0] UID = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
   typedef struct {logic [63:0] v; int n, rn; logic [63:0] e;
      logic aw;} sfmcd_row_t;
   sfmcd_row_t  rows[8];          // id and width rows
   logic [27:0] sec[6];           // address, locks, start, select
   logic [18:0] prm[4];           // parameter, dummy, wrap
   logic        clk, reset_n, four_line_mode, lock2, lock3;
   logic [4:0]  bp;               // protection setting
   logic [1:0]  susp;             // suspend state
   logic [63:0] rd;               // data read back
   wire         cs_n, sclk, write_latch_flag, in_progress_flag, aw, ce, se, sel, sreq;
   wire  [3:0]  io_in, io_out, io_oe_n, dummy;
   wire  [6:0]  wrap;
   int          error_cnt, total_checks, ce_n, se_n, sr_n, n0, i;

   sfmcd_top #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .MEMORY_TYPE(TY),
      .CAPACITY_CODE(CP), .UNIQUE_ID(UID), .CHIP_ERASE_US(20),
      .SECTOR_ERASE_US(1), .CLK_MHZ(40)) u_dut (.CLK(clk),
      .RESET_N(reset_n), .CS_N(cs_n), .SCLK(sclk), .IO_IN(io_in),
      .IO_OUT(io_out), .IO_OE_N(io_oe_n), .FOUR_LINE_MODE(four_line_mode),
      .BLOCK_PROTECT_FIELD(bp), .SEC_REG_TWO_LOCK(lock2),
      .SEC_REG_THREE_LOCK(lock3), .SUSPEND_FLAGS(susp),
      .WRITE_LATCH_FLAG(write_latch_flag), .IN_PROGRESS_FLAG(in_progress_flag),
      .ADDRESS_WIDTH_FLAG(aw), .DUMMY_CLOCKS(dummy), .WRAP_BYTES(wrap),
      .CHIP_ERASE_START(ce), .SEC_ERASE_START(se),
      .SEC_ERASE_SELECT(sel), .SUSPEND_REQUEST(sreq));
   sfmcd_host u_host (.clk(clk), .io_out(io_out), .cs_n(cs_n),
      .sclk(sclk), .io_in(io_in));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // count start and suspend pulses
   always @(posedge clk) begin
      ce_n <= ce_n + (ce === 1'b1);
      se_n <= se_n + (se === 1'b1);
      sr_n <= sr_n + (sreq === 1'b1);
   end

   // one command, current mode
   task automatic go(input logic [63:0] v, input int n, input int rn);
      @(posedge clk);
      u_host.cmd(v, n, four_line_mode, rn, rd);
   endtask
   // bounded wait for idle
   task automatic wait_idle();
      int k;
      for (k = 0; k < 2000 && in_progress_flag !== 1'b0; k++)
         @(posedge clk);
      if (in_progress_flag !== 1'b0) begin
         error_cnt++;
         results();
      end
   endtask
   // verdict and end of run
   task automatic results();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      {reset_n, four_line_mode, bp, lock2, lock3, susp} = '0;
      {error_cnt, total_checks, ce_n, se_n, sr_n} = '0;
      rows = '{'{64'h9F, 8, 24, {MK, TY, CP}, 0},
         '{64'h9000_0000, 32, 16, {MK, DV}, 0},
         '{64'h4B_0000_0000, 40, 64, UID[127:64], 0},
         '{64'hB7, 8, 0, 0, 1}, '{64'h4B00_0000_0000, 48, 32, UID[127:96], 1},
         '{64'h9F, 8, 8, MK, 1}, '{64'hE9, 8, 0, 0, 0},
         '{64'h4B_0000_0000, 40, 32, UID[127:96], 0}};
      sec = '{{24'h00_2000, 4'h8}, {24'h00_23FF, 4'h6}, {24'h00_4000, 4'h0},
         {24'h01_2000, 4'h0}, {24'h00_2400, 4'h0}, {24'h00_3000, 4'hB}};
      prm = '{{8'h11, 4'h6, 7'h10}, {8'h00, 4'h4, 7'h08},
         {8'h22, 4'h8, 7'h20}, {8'h33, 4'h8, 7'h40}};
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (i = 0; i < 8; i++) begin
         go(rows[i].v, rows[i].n, rows[i].rn);
         `CHK("id data", rows[i].e, rd)
         `CHK("width", rows[i].aw, aw)
         `CHK("idle oe", 4'hF, io_oe_n)
      end
      $display("id rows done");
      go(64'h60, 8, 0);
      `CHK("erase no latch", 0, ce_n)
      go(64'h06, 8, 0);
      go(64'h0C0, 9, 0);
      go(64'h30, 7, 0);
      `CHK("erase bad frame", 0, ce_n)
      bp <= 5'h04;
      go(64'hC7, 8, 0);
      `CHK("erase protected", 0, ce_n)
      `CHK("latch kept", 1'b1, write_latch_flag)
      bp <= 5'h00;
      go(64'hC7, 8, 0);
      `CHK("erase start", 1, ce_n)
      `CHK("erase latch", 1'b0, write_latch_flag)
      susp <= 2'h1;
      go(64'h75, 8, 0);
      `CHK("suspend refused", 0, sr_n)
      go(64'hB7, 8, 0);
      `CHK("busy ignores", 1'b0, aw)
      susp <= 2'h0;
      go(64'h75, 8, 0);
      `CHK("suspend taken", 1, sr_n)
      wait_idle();
      $display("chip erase done");
      for (i = 0; i < 6; i++) begin
         {lock2, lock3} <= sec[i][3:2];
         n0 = se_n;
         go(64'h06, 8, 0);
         go({8'h44, sec[i][27:4]}, 32, 0);
         `CHK("sec start", sec[i][1], se_n - n0 == 1)
         if (sec[i][1]) begin
            `CHK("sec select", sec[i][0], sel)
            `CHK("sec latch", 1'b0, write_latch_flag)
            wait_idle();
         end
      end
      {lock2, lock3} <= 2'b00;
      n0 = se_n;
      go(64'h4B_0000_0000, 40, 0);
      go(64'h4400_2000, 32, 0);
      go(64'h06, 8, 0);
      go(64'h2200_1000, 31, 0);
      `CHK("sec refused", n0, se_n)
      $display("sec erase done");
      go(64'hC011, 16, 0);
      `CHK("param single", 4'h4, dummy)
      four_line_mode <= 1'b1;
      for (i = 0; i < 4; i++) begin
         go({8'hC0, prm[i][18:11]}, 16, 0);
         `CHK("dummy", prm[i][10:7], dummy)
         `CHK("wrap", prm[i][6:0], wrap)
      end
      four_line_mode <= 1'b0;
      go(64'hB7, 8, 0);
      `CHK("wrap kept", 7'h40, wrap)
      $display("params done");
      reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK("reset width", 1'b0, aw)
      `CHK("reset dummy", 4'h4, dummy)
      `CHK("reset wrap", 7'h08, wrap)
      $display("reset done");
      results();
   end
endmodule

bind sfmcd_top sfmcd_top_chk #(.CHIP_ERASE_US(CHIP_ERASE_US),
   .SECTOR_ERASE_US(SECTOR_ERASE_US), .CLK_MHZ(CLK_MHZ)) u_chk (.CLK,
   .RESET_N, .CS_N, .FOUR_LINE_MODE, .BLOCK_PROTECT_FIELD,
   .SEC_REG_TWO_LOCK, .SEC_REG_THREE_LOCK, .SUSPEND_FLAGS,
   .WRITE_LATCH_FLAG, .IN_PROGRESS_FLAG, .ADDRESS_WIDTH_FLAG,
   .DUMMY_CLOCKS, .WRAP_BYTES, .CHIP_ERASE_START, .SEC_ERASE_START,
   .SEC_ERASE_SELECT, .SUSPEND_REQUEST, .IO_OE_N);

/* File: inc/sfmcd_map.vh */
`ifndef SFMCD_MAP_VH
`define SFMCD_MAP_VH

// opcodes handled by the decoder
`define SFMCD_OP_WRITE_ENABLE   8'h06
`define SFMCD_OP_ERASE_CHIP_A   8'h60
`define SFMCD_OP_ERASE_CHIP_B   8'hC7
`define SFMCD_OP_SET_READ_PARAM 8'hC0
`define SFMCD_OP_ENTER_WIDE     8'hB7
`define SFMCD_OP_EXIT_WIDE      8'hE9
`define SFMCD_OP_MAKER_DEVICE   8'h90
`define SFMCD_OP_THREE_BYTE_ID  8'h9F
`define SFMCD_OP_UNIQUE_ID      8'h4B
`define SFMCD_OP_ERASE_SEC_REG  8'h44
`define SFMCD_OP_SUSPEND        8'h75

// field lengths in bits
`define SFMCD_OPCODE_BITS       6'h08
`define SFMCD_ADDR_NARROW_BITS  6'h18
`define SFMCD_ADDR_WIDE_BITS    6'h20
`define SFMCD_DUMMY_BYTE_BITS   6'h08
`define SFMCD_PARAM_BITS        6'h08
`define SFMCD_STEP_SINGLE       6'h01
`define SFMCD_STEP_QUAD         6'h04

// read-parameter byte fields
`define SFMCD_DUMMY_MSB         5
`define SFMCD_DUMMY_LSB         4
`define SFMCD_WRAP_MSB          1
`define SFMCD_WRAP_LSB          0
`define SFMCD_DUMMY_RESERVED    2'h3
`define SFMCD_DUMMY_CODE_4      2'h0
`define SFMCD_DUMMY_CODE_6      2'h1
`define SFMCD_DUMMY_4           4'h4
`define SFMCD_DUMMY_6           4'h6
`define SFMCD_DUMMY_8           4'h8
`define SFMCD_WRAP_CODE_8       2'h0
`define SFMCD_WRAP_CODE_16      2'h1
`define SFMCD_WRAP_CODE_32      2'h2
`define SFMCD_WRAP_8            7'h08
`define SFMCD_WRAP_16           7'h10
`define SFMCD_WRAP_32           7'h20
`define SFMCD_WRAP_64           7'h40

// security-register address decode
`define SFMCD_SR_TOP_MSB        23
`define SFMCD_SR_TOP_LSB        16
`define SFMCD_SR_SEL_MSB        15
`define SFMCD_SR_SEL_LSB        12
`define SFMCD_SR_GAP_MSB        11
`define SFMCD_SR_GAP_LSB        10
`define SFMCD_SR_TOP_VAL        8'h00
`define SFMCD_SR_SEL_TWO        4'h2
`define SFMCD_SR_SEL_THREE      4'h3
`define SFMCD_SR_GAP_VAL        2'h0

// self-timed cycle durations and clock
`define SFMCD_CHIP_ERASE_US     1000
`define SFMCD_SECTOR_ERASE_US   100
`define SFMCD_CLK_MHZ           40

// pin drive patterns, enables active low
`define SFMCD_OE_NONE           4'hF
`define SFMCD_OE_SINGLE         4'hD
`define SFMCD_OE_QUAD           4'h0

`endif
